/* File: bench/hbp_host_bus_port_checker.sv */
// Checker for host bus port pin timing and reset effects.
// Sees top ports only; bound from the bench top file.
`timescale 1ns/1ps
module hbp_host_bus_port_checker (
   input wire logic       clk_i,
   input wire logic       srst_i,
   input wire logic       hw_rst_n_i,
   input wire logic       strobe_convention_sel_i,
   input wire logic       cs_n_i,
   input wire logic       read_or_data_strobe_n_i,
   input wire logic       write_or_dir_i,
   input wire logic       ad_oe_o,
   input wire logic       ready_oe_o,
   input wire logic       irq_oe_o,
   input wire logic [7:0] irq_flags_i,
   input wire logic [7:0] irq_mask_i,
   input wire logic       inactive_o,
   input wire logic       power_down_o,
   input wire logic [7:0] smon_sel_o,
   input wire logic [7:0] loop_clk_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   logic       rd;     // Enabled read decode
   logic       wr;     // Enabled write phase
   logic [2:0] idle_q; // Quiet cycles, saturating at 4
   assign rd = !cs_n_i && !read_or_data_strobe_n_i &&
               (write_or_dir_i || !strobe_convention_sel_i);
   assign wr = !cs_n_i && !write_or_dir_i &&
               (!read_or_data_strobe_n_i || !strobe_convention_sel_i);
   // Counts cycles with chip select high and no reset
   always_ff @(posedge clk_i) begin
      if (srst_i || !hw_rst_n_i || !cs_n_i) begin
         idle_q <= 3'h0;
      end else if (idle_q != 3'h4) begin
         idle_q <= idle_q + 3'h1;
      end
   end
   // Read decode rising outside reset
   sequence s_rd_go;
      !rd ##1 (rd && hw_rst_n_i);
   endsequence
   // Three fetch cycles, then ready
   sequence s_rd_wait;
      !ready_oe_o [*3] ##1 (ready_oe_o || !rd);
   endsequence
   a_bus_release:
      assert property (!rd |-> !ad_oe_o) else $error("bus driven idle");
   a_read_drive:
      assert property (rd && hw_rst_n_i |-> ad_oe_o)
      else $error("read not driven");
   a_ready_delay:
      assert property (s_rd_go |-> s_rd_wait) else $error("ready timing");
   a_ready_write:
      assert property (wr && hw_rst_n_i |-> ready_oe_o)
      else $error("no ready on write");
   a_ready_idle:
      assert property (cs_n_i |-> !ready_oe_o) else $error("ready unselected");
   a_irq_level:
      assert property (irq_oe_o == |(irq_flags_i & ~irq_mask_i))
      else $error("interrupt level");
   a_inactive_hold:
      assert property (inactive_o == (!hw_rst_n_i || power_down_o))
      else $error("inactive level");
   a_reset_pd:
      assert property (!hw_rst_n_i |=> power_down_o)
      else $error("power-down not set");
   a_reset_freq:
      assert property (!hw_rst_n_i |=> !smon_sel_o[1:0] && !loop_clk_o[1:0])
      else $error("frequency fields kept");
   a_idle_stable:
      assert property (idle_q == 3'h4 |-> $stable(smon_sel_o[1:0]) &&
         $stable(loop_clk_o[1:0]) && $stable(power_down_o))
      else $error("register changed unselected");
endmodule

/* File: bench/hbp_host_bus_port_tb_top.sv */
// Bench top: host model, design, scenarios and the checker bind.
// Assumes package, checker and host model compile first.
`timescale 1ns/1ps
module hbp_host_bus_port_tb_top;
   import hbp_pkg::*;
   logic       clk_i = 1'b0;         // System clock
   logic       srst_i = 1'b1;        // Sync reset
   logic       hw_rst_n_i = 1'b1;    // Reset pin
   logic [7:0] irq_flags_i = 8'h00;  // Core flags
   logic [7:0] irq_mask_i = 8'hFF;   // Core masks
   logic [3:0] core_status_i = 4'h9; // Core status
   logic       strobe_convention_sel_i, addr_multiplex_sel_i, cs_n_i;
   logic       read_or_data_strobe_n_i, write_or_dir_i, ale_i, ok;
   logic       ad_oe_o, ready_n_o, ready_oe_o, irq_n_o, irq_oe_o;
   logic       inactive_o, power_down_o;
   logic [7:0] ad_i, ad_o, addr_i, global_ctrl_o, smon_sel_o, loop_clk_o;
   logic [7:0] q, d;
   int         err_total = 0, n_tests = 0, cyc = 0, clash;
   hbp_host_model hm (.clk_i, .dev_ad_i(ad_o), .dev_oe_i(ad_oe_o),
      .rdy_n_i(ready_n_o), .rdy_oe_i(ready_oe_o),
      .conv_o(strobe_convention_sel_i), .mux_o(addr_multiplex_sel_i),
      .cs_n_o(cs_n_i), .stb_n_o(read_or_data_strobe_n_i),
      .sec_o(write_or_dir_i), .ale_o(ale_i), .addr_o(addr_i),
      .ad_o(ad_i), .clash_o(clash));
   hbp_host_bus_port uut (.clk_i, .srst_i, .hw_rst_n_i,
      .strobe_convention_sel_i, .addr_multiplex_sel_i, .cs_n_i,
      .read_or_data_strobe_n_i, .write_or_dir_i, .ale_i, .ad_i, .ad_o,
      .ad_oe_o, .addr_i, .ready_n_o, .ready_oe_o, .irq_n_o, .irq_oe_o,
      .irq_flags_i, .irq_mask_i, .core_status_i, .inactive_o,
      .power_down_o, .global_ctrl_o, .smon_sel_o, .loop_clk_o);
   // Clock and hang guard
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         wrap_up();
      end
   end
   // Masked compare; unknown bits under the mask fail
   task automatic check(input logic [7:0] got, exp, m);
      n_tests++;
      if (((got ^ exp) & m) !== 8'h00) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Register values right after the synchronous reset
   task automatic t_reset_vals();
      hm.acc(1'b0, 1'b1, 1'b0, 1'b0, HBP_OFS_GLOBAL, 8'h00, q, ok);
      check(q, {core_status_i, 4'h1}, 8'hF1);
      check({7'h00, ok}, 8'h01, 8'hFF);
      hm.acc(1'b1, 1'b0, 1'b0, 1'b0, HBP_OFS_SMON_SEL, 8'h00, q, ok);
      check(q, 8'h00, 8'h03);
      q = {power_down_o, inactive_o, loop_clk_o[1:0], 4'h0};
      check(q, 8'hC0, 8'hF0);
   endtask
   // Every convention and addressing mode, RAM and registers
   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         d = 8'h4B + 8'(i * 17);
         hm.acc(i[0], i[1], 1'b0, 1'b1, 8'h40 + 8'(i), d, q, ok);
         hm.acc(i[0], i[1], 1'b0, 1'b1, HBP_OFS_SMON_SEL, ~d, q, ok);
         hm.acc(i[0], i[1], 1'b0, 1'b1, HBP_OFS_LOOP_CLK, d, q, ok);
         check(smon_sel_o, ~d, 8'hFF);
         check(loop_clk_o, d, 8'hFF);
         hm.acc(i[0], i[1], 1'b0, 1'b0, 8'h40 + 8'(i), 8'h00, q, ok);
         check(q, d, 8'hFF);
      end
      check(8'(clash), 8'h00, 8'hFF);
   endtask
   // Chip select high: write and read both ignored
   task automatic t_cs_refuse();
      hm.acc(1'b0, 1'b1, 1'b1, 1'b1, HBP_OFS_SMON_SEL, 8'h00, q, ok);
      check(smon_sel_o, 8'h81, 8'hFF);
      hm.acc(1'b1, 1'b0, 1'b1, 1'b0, HBP_OFS_SMON_SEL, 8'h00, q, ok);
      check({7'h00, ok}, 8'h00, 8'hFF);
   endtask
   // Global write, then a pulse on the reset pin
   task automatic t_pin_reset();
      hm.acc(1'b0, 1'b0, 1'b0, 1'b1, HBP_OFS_GLOBAL, 8'h06, q, ok);
      check(global_ctrl_o, 8'h06, 8'hFF);
      check({6'h00, power_down_o, inactive_o}, 8'h00, 8'hFF);
      hm.acc(1'b1, 1'b1, 1'b0, 1'b0, HBP_OFS_GLOBAL, 8'h00, q, ok);
      check(q, {core_status_i, 4'h6}, 8'hFF);
      hw_rst_n_i = 1'b0;
      @(negedge clk_i);
      check({7'h00, inactive_o}, 8'h01, 8'hFF);
      @(negedge clk_i);
      hw_rst_n_i = 1'b1;
      q = {power_down_o, 1'b0, smon_sel_o[1:0], 2'h0, loop_clk_o[1:0]};
      check(q, 8'h80, 8'hFF);
   endtask
   // Interrupt level for flag and mask pairs
   task automatic t_irq();
      logic [15:0] tbl [6];
      tbl = '{16'h0100, 16'h0101, 16'h807F, 16'h0000, 16'hF00F, 16'hF0F0};
      for (int i = 0; i < 6; i++) begin
         {irq_flags_i, irq_mask_i} = tbl[i];
         @(negedge clk_i);
         d = {6'h00, |(tbl[i][15:8] & ~tbl[i][7:0]), 1'b0};
         check({6'h00, irq_oe_o, irq_n_o}, d, 8'hFF);
      end
   endtask
   // Counts, verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      t_reset_vals();
      t_modes();
      t_cs_refuse();
      t_pin_reset();
      t_irq();
      wrap_up();
   end
endmodule
bind hbp_host_bus_port hbp_host_bus_port_checker chk (.clk_i, .srst_i,
   .hw_rst_n_i, .strobe_convention_sel_i, .cs_n_i,
   .read_or_data_strobe_n_i, .write_or_dir_i, .ad_oe_o, .ready_oe_o,
   .irq_oe_o, .irq_flags_i, .irq_mask_i, .inactive_o, .power_down_o,
   .smon_sel_o, .loop_clk_o);

/* File: bench/hbp_host_model.sv */
// Host processor model: drives the port pins, resolves the bus.
// Pins change on falling edges; ready has a pull-up.
`timescale 1ns/1ps
module hbp_host_model (
   input  wire logic       clk_i,    // System clock
   input  wire logic [7:0] dev_ad_i, // Device bus value
   input  wire logic       dev_oe_i, // Device bus enable
   input  wire logic       rdy_n_i,  // Ready level
   input  wire logic       rdy_oe_i, // Ready drive
   output logic            conv_o,   // Strobe convention
   output logic            mux_o,    // Addressing mode
   output logic            cs_n_o,   // Chip select
   output logic            stb_n_o,  // First strobe
   output logic            sec_o,    // Second strobe
   output logic            ale_o,    // Address latch
   output logic      [7:0] addr_o,   // Separate address
   output logic      [7:0] ad_o,     // Resolved bus
   output int              clash_o   // Bus fights
);
   logic       drv = 1'b0; // Host drives the bus
   logic [7:0] dq  = 8'h00; // Host bus value
   logic [7:0] flt = 8'h55; // Released bus, changes each cycle
   assign ad_o = dev_oe_i ? dev_ad_i : (drv ? dq : flt);
   initial begin
      {conv_o, mux_o, cs_n_o, stb_n_o, sec_o, ale_o} = 6'h0E;
      addr_o = 8'h00;
      clash_o = 0;
   end
   // Floating pattern and contention count
   always @(posedge clk_i) begin
      flt <= ~flt;
      if (drv && dev_oe_i) begin
         clash_o <= clash_o + 1;
      end
   end
   // Latch phase, strobe phase, bounded wait for ready, release
   task automatic acc(input logic cv, mx, cs, wr,
                      input logic [7:0] a, d,
                      output logic [7:0] q, output logic ok);
      ok = 1'b0;
      q = 8'h00;
      @(negedge clk_i);
      conv_o <= cv;
      mux_o <= mx;
      addr_o <= mx ? ~a : a;
      dq <= mx ? a : ~a;
      drv <= 1'b1;
      sec_o <= !(cv && wr);
      ale_o <= 1'b1;
      @(negedge clk_i);
      ale_o <= 1'b0;
      @(negedge clk_i);
      cs_n_o <= cs;
      stb_n_o <= !cv && wr;
      sec_o <= !wr;
      dq <= d;
      drv <= wr;
      for (int n = 0; n < 12 && !ok; n++) begin
         @(posedge clk_i);
         ok = rdy_oe_i && !rdy_n_i;
         q = ad_o;
      end
      @(negedge clk_i);
      {cs_n_o, stb_n_o, sec_o} <= 3'h7;
      drv <= 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
endmodule

/* File: logic/hbp_host_bus_port.sv */
// Host bus port: 8-bit processor access to the transceiver registers.
// Assumes host pins are synchronous to clk_i; the board resolves the
// open-drain and bidirectional pins from the enables given here.
`timescale 1ns/1ps
module hbp_host_bus_port
   import hbp_pkg::*;
#(
   parameter int AW = 8 // Register address width
) (
   input  wire logic          clk_i,                  // System clock
   input  wire logic          srst_i,                 // Sync reset, high
   input  wire logic          hw_rst_n_i,             // Reset pin, low
   input  wire logic          strobe_convention_sel_i,// 1: data strobe
   input  wire logic          addr_multiplex_sel_i,   // 1: addr_multiplex_sel bus
   input  wire logic          cs_n_i,                 // Chip select
   input  wire logic          read_or_data_strobe_n_i,// First strobe
   input  wire logic          write_or_dir_i,         // Second strobe
   input  wire logic          ale_i,                  // Address latch
   input  wire logic [7:0]    ad_i,                   // Bus level in
   output logic      [7:0]    ad_o,                   // Bus drive value
   output logic               ad_oe_o,                // Bus drive enable
   input  wire logic [AW-1:0] addr_i,                 // Separate address
   output logic               ready_n_o,              // Ready level
   output logic               ready_oe_o,             // Ready drive
   output logic               irq_n_o,                // Interrupt level
   output logic               irq_oe_o,               // Interrupt drive
   input  wire logic [7:0]    irq_flags_i,            // Core flags
   input  wire logic [7:0]    irq_mask_i,             // Core masks, 1=off
   input  wire logic [3:0]    core_status_i,          // Core status
   output logic               inactive_o,             // Hold core idle
   output logic               power_down_o,           // Power-down bit
   output logic      [7:0]    global_ctrl_o,          // Reg 0x00
   output logic      [7:0]    smon_sel_o,             // Reg 0x01
   output logic      [7:0]    loop_clk_o              // Reg 0x22
);

   // Read sequencing states
   typedef enum logic [1:0] {
      ST_IDLE,  // No read in progress
      ST_FETCH, // RAM read issued
      ST_LOAD,  // Output register already loaded
      ST_DONE   // Data on bus, ready asserted
   } hbp_rd_st_t;

   hbp_pins_t   pins;          // Current pin bundle
   hbp_pins_t   prev_q;        // Pins one clock ago
   logic        rst_all;       // Any reset source active
   logic        ds_mode;       // Data strobe convention selected
   logic        rd_active;     // Enabled read strobe asserted
   logic        wr_active;     // Enabled write in its low phase
   logic        wr_event;      // Write completes this clock
   logic        rd_start;      // Read begins this clock
   logic        ale_fall;      // Address strobe falling edge
   logic [AW-1:0] addr_q;      // Latched address
   logic [AW-1:0] addr_eff;    // Address used by this access
   logic [7:0]  wdata;         // Data written on completion
   logic        ram_we;        // Write to general RAM
   logic        ram_re;        // Read from general RAM
   logic [7:0]  ram_rdata;     // RAM registered read data
   logic        rd_sel_ram_q;  // Read targets RAM, not a flop reg
   logic [7:0]  rd_reg_q;      // Value of flop reg held for read
   logic [7:0]  rd_data_q;     // Bus output register
   hbp_rd_st_t  st_q;          // Read state
   hbp_rd_st_t  st_d;          // Next read state
   logic [7:0]  global_q;      // Global mode/status control bits
   logic [7:0]  smon_q;        // Serial monitor select
   logic [7:0]  loop_q;        // Loop clock control
   logic [7:0]  global_rd;     // Global reg as read back
   logic        irq_any;       // Any unmasked flag set
   logic        ready_any;     // Transfer can complete now
   logic        rd_seen_q;     // Read decode one clock ago

   // Gather the pins into one bundle
   always_comb begin
      pins.cs_n     = cs_n_i;
      pins.strobe_n = read_or_data_strobe_n_i;
      pins.second   = write_or_dir_i;
      pins.ale      = ale_i;
      pins.ad       = ad_i;
   end

   // Reset pin acts as a level; it joins the system reset
   assign rst_all = srst_i | ~hw_rst_n_i;

   // Transceiver held inactive while the pin is low or powered down
   assign inactive_o = ~hw_rst_n_i | global_q[HBP_PD_BIT];

   // Previous pin sample for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         // Idle pin levels, so no false edge follows reset
         prev_q <= '{cs_n: 1'b1, strobe_n: 1'b1, second: 1'b1,
                     ale: 1'b0, ad: 8'h00};
      end else begin
         // Keep this clock's pins for the next clock's edge tests
         prev_q <= pins;
      end
   end

   // Convention select is taken as static by the host
   assign ds_mode = strobe_convention_sel_i;

   // Read strobe decode per convention
   always_comb begin
      if (ds_mode) begin
         // Data strobe low with direction high reads
         rd_active = ~pins.cs_n & ~pins.strobe_n & pins.second;
      end else begin
         // Read strobe alone controls reads
         rd_active = ~pins.cs_n & ~pins.strobe_n;
      end
   end

   // Write decode: write completes on rising edge of the strobe
   always_comb begin
      if (ds_mode) begin
         // Data strobe rising while direction was low
         wr_active = ~pins.cs_n & ~pins.strobe_n & ~pins.second;
         wr_event  = ~prev_q.cs_n & ~prev_q.strobe_n & ~prev_q.second
                     & pins.strobe_n;
      end else begin
         // Write strobe rising; first strobe plays no part
         wr_active = ~pins.cs_n & ~pins.second;
         wr_event  = ~prev_q.cs_n & ~prev_q.second
                     & pins.second;
      end
   end

   // Data captured while the strobe was still low
   assign wdata = prev_q.ad;

   // Remember the read decode, so a held strobe starts only one read
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         // Idle after reset: a strobe already low starts a read
         rd_seen_q <= 1'b0;
      end else begin
         // Follow the decode every clock
         rd_seen_q <= rd_active;
      end
   end

   // Read begins on the first clock the decode is active; the RAM
   // is read at this edge, so the address must already be latched
   assign rd_start = rd_active & ~rd_seen_q;

   // Address strobe falling edge
   assign ale_fall = prev_q.ale & ~pins.ale;

   // Address latch from the bus chosen by the addressing mode
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         addr_q <= '0;
      end else if (ale_fall) begin
         if (addr_multiplex_sel_i) begin
            // Multiplexed: the address rides on the shared bus
            addr_q <= pins.ad[AW-1:0];
         end else begin
            // Separate: the address comes from its own pins
            addr_q <= addr_i;
         end
      end
   end

   // Separate address pins are transparent while the strobe stays high
   always_comb begin
      if (!addr_multiplex_sel_i && pins.ale) begin
         // Latch strobe high: address pins pass straight through
         addr_eff = addr_i;
      end else begin
         // Otherwise the address caught at the strobe's fall
         addr_eff = addr_q;
      end
   end

   // RAM strobes; flop registers are excluded from the RAM
   always_comb begin
      ram_we = wr_event;
      ram_re = rd_start;
      if (addr_eff == HBP_OFS_GLOBAL[AW-1:0] ||
          addr_eff == HBP_OFS_SMON_SEL[AW-1:0] ||
          addr_eff == HBP_OFS_LOOP_CLK[AW-1:0]) begin
         // Flop registers live outside the RAM, so block the write
         ram_we = 1'b0;
      end
   end

   // General register RAM; no reset reaches it
   hbp_regmem #(
      .AW (AW),
      .DW (8)
   ) u_mem (
      .clk_i   (clk_i),
      .we_i    (ram_we),
      .waddr_i (addr_eff),
      .wdata_i (wdata),
      .re_i    (ram_re),
      .raddr_i (addr_eff),
      .rdata_o (ram_rdata)
   );

   // Global register: power-down set by reset, other bits kept
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         // Other bits keep whatever they held before reset
         global_q[HBP_PD_BIT] <= HBP_PD_RST;
      end else if (wr_event && addr_eff == HBP_OFS_GLOBAL[AW-1:0]) begin
         // Host write replaces the whole byte
         global_q <= wdata;
      end
   end

   // Serial monitor select: host clock field cleared by reset
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         smon_q[HBP_FREQ_LSB+:2] <= HBP_FREQ_RST;
      end else if (wr_event && addr_eff == HBP_OFS_SMON_SEL[AW-1:0]) begin
         // Host write replaces the whole byte
         smon_q <= wdata;
      end
   end

   // Loop clock control: clock field cleared by reset
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         loop_q[HBP_FREQ_LSB+:2] <= HBP_FREQ_RST;
      end else if (wr_event && addr_eff == HBP_OFS_LOOP_CLK[AW-1:0]) begin
         // Host write replaces the whole byte
         loop_q <= wdata;
      end
   end

   // Global read value: status nibble comes from the core
   always_comb begin
      global_rd = global_q;
      global_rd[HBP_STATUS_LSB+:4] = core_status_i;
   end

   // Read source capture at read start
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         // Default source is the RAM
         rd_sel_ram_q <= 1'b1;
         rd_reg_q     <= 8'h00;
      end else if (rd_start) begin
         // Snapshot a flop register now, so a later write cannot tear it
         rd_sel_ram_q <= 1'b0;
         if (addr_eff == HBP_OFS_GLOBAL[AW-1:0]) begin
            rd_reg_q <= global_rd;
         end else if (addr_eff == HBP_OFS_SMON_SEL[AW-1:0]) begin
            rd_reg_q <= smon_q;
         end else if (addr_eff == HBP_OFS_LOOP_CLK[AW-1:0]) begin
            rd_reg_q <= loop_q;
         end else begin
            rd_sel_ram_q <= 1'b1; // Plain RAM location
         end
      end
   end

   // Read state next-value logic
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            // Wait for a fresh read
            if (rd_start) begin
               st_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            // Abandon the read if the strobe is withdrawn early
            st_d = rd_active ? ST_LOAD : ST_IDLE;
         end
         ST_LOAD: begin
            // Output register took the read data at the last edge
            st_d = rd_active ? ST_DONE : ST_IDLE;
         end
         ST_DONE: begin
            // Hold ready until the host lets the strobe go
            if (!rd_active) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            // Unused codes recover to idle
            st_d = ST_IDLE;
         end
      endcase
   end

   // Read state register
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Bus output register, loaded once RAM data is valid
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         rd_data_q <= 8'h00;
      end else if (st_q == ST_FETCH) begin
         // RAM data is valid one clock after the read issue
         rd_data_q <= rd_sel_ram_q ? ram_rdata : rd_reg_q;
      end
   end

   // Drive the bus only during an enabled read
   always_comb begin
      // Value stands at the last read; only the enable matters
      ad_o    = rd_data_q;
      ad_oe_o = rd_active & hw_rst_n_i;
   end

   // Ready: read data loaded, or write phase (completes at strobe rise)
   // Writes need no wait states: data is taken as the strobe rises,
   // so the host may end the write as soon as it sees ready
   assign ready_any = (rd_active & (st_q == ST_DONE)) | wr_active;

   // Open-drain ready: pulled low when the transfer can complete
   always_comb begin
      ready_n_o  = 1'b0;
      ready_oe_o = ready_any & hw_rst_n_i;
   end

   // Interrupt from unmasked flags
   // Flags and masks belong to the core; only the pin lives here
   assign irq_any = |(irq_flags_i & ~irq_mask_i);

   // Open-drain interrupt: pulled low while any unmasked flag is set
   always_comb begin
      irq_n_o  = 1'b0;
      irq_oe_o = irq_any;
   end

   // Register views for the core
   always_comb begin
      power_down_o  = global_q[HBP_PD_BIT];
      global_ctrl_o = global_q;
      smon_sel_o    = smon_q;
      loop_clk_o    = loop_q;
   end

   // No test access port logic lives here, so reset cannot touch it

endmodule

/* File: logic/hbp_pkg.sv */
// Constants, field layouts and carrier types for the host bus port.
// Assumes one 10 MHz system clock and host pins already synchronous to it.
package hbp_pkg;

   // Register offsets on the host port
   localparam logic [7:0] HBP_OFS_GLOBAL   = 8'h00;
   localparam logic [7:0] HBP_OFS_SMON_SEL = 8'h01;
   localparam logic [7:0] HBP_OFS_LOOP_CLK = 8'h22;

   // Field positions
   localparam int HBP_PD_BIT       = 0;  // Power-down mode bit
   localparam int HBP_FREQ_LSB     = 0;  // Two-bit frequency fields
   localparam int HBP_STATUS_LSB   = 4;  // Read-only status nibble

   // Values after reset
   localparam logic       HBP_PD_RST   = 1'b1;
   localparam logic [1:0] HBP_FREQ_RST = 2'h0;

   // Read pipeline stages (RAM + output register); ready comes three clocks after the strobe
   localparam int HBP_RD_LAT = 2;

   // Sampled host pins, one bundle per clock
   typedef struct packed {
      logic       cs_n;     // Chip select, active low
      logic       strobe_n; // Read strobe or data strobe
      logic       second;   // Write strobe or direction select
      logic       ale;      // Address latch strobe
      logic [7:0] ad;       // Multiplexed address/data bus
   } hbp_pins_t;

   // Open-drain pin drive pair
   typedef struct packed {
      logic level; // Level put on the pin when driven
      logic oe;    // High while the pin is driven
   } hbp_od_t;

endpackage

/* File: logic/hbp_regmem.sv */
// General register RAM behind the host bus port.
// Assumes one clock; contents have no reset and are undefined at start.
`timescale 1ns/1ps
module hbp_regmem
   import hbp_pkg::*;
#(
   parameter int AW = 8, // Address width
   parameter int DW = 8  // Data width
) (
   input  wire logic          clk_i,   // System clock
   input  wire logic          we_i,    // Write enable
   input  wire logic [AW-1:0] waddr_i, // Write address
   input  wire logic [DW-1:0] wdata_i, // Write data
   input  wire logic          re_i,    // Read enable
   input  wire logic [AW-1:0] raddr_i, // Read address
   output logic      [DW-1:0] rdata_o  // Registered read data
);

   // Storage array, deliberately without reset
   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   // Write port
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge clk_i) begin
      if (re_i) begin
         rdata_o <= mem_q[raddr_i];
      end
   end

endmodule
